// ### ifsp_pkg.sv
// Constants and types for the isolated fast serial port
package ifsp_pkg;
    localparam int          DATA_BITS      = 8;
    localparam int          FRAME_BITS     = 10;
    localparam logic [3:0]  BIT_CNT_LAST   = 4'h8;
    localparam logic [3:0]  BIT_CNT_ZERO   = 4'h0;
    localparam logic        START_LEVEL    = 1'b0;
    localparam logic        IDLE_LEVEL     = 1'b1;
    localparam logic        CHAN_FIRST     = 1'b0;
    localparam logic        CHAN_SECOND    = 1'b1;
    localparam logic [7:0]  MODE_HOLD_RST  = 8'h10;
    localparam logic [7:0]  MODE_RUN       = 8'h00;

    // Gray coded along idle -> rx -> deliver
    typedef enum logic [1:0] {
        IFSP_IDLE    = 2'b00,
        IFSP_RX      = 2'b01,
        IFSP_DELIVER = 2'b11,
        IFSP_TX      = 2'b10
    } ifsp_state_t;
endpackage

// ### ifsp_core.sv
// Isolated fast serial port framer, router and flow control
`timescale 1ns/100ps
module ifsp_core (
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Option bits from nonvolatile memory, static after load
    input  wire logic        opt_first_en,
    input  wire logic        opt_second_en,
    input  wire logic [7:0]  bit_mode,
    input  wire logic        iso_serial_clock,
    input  wire logic        iso_serial_in,
    output logic             iso_serial_out,
    output logic             iso_clear_to_send,
    output logic             pins_on_second,
    // Outgoing byte request from the channels
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_origin,
    output logic             tx_ready,
    // Incoming byte delivery
    output logic             rx_valid,
    output logic [7:0]       rx_data,
    output logic             rx_to_second,
    input  wire logic        rx_ready
);
    logic        clk_s1_r, clk_s2_r, clk_s3_r;
    logic        clk_s1_nxt, clk_s2_nxt, clk_s3_nxt;
    logic        din_s1_r, din_s2_r;
    logic        din_s1_nxt, din_s2_nxt;
    logic        port_en;
    logic        rise;
    logic        deliver;
    ifsp_pkg::ifsp_state_t state_r, state_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [8:0]  shreg_r, shreg_nxt;
    logic        sout_r, sout_nxt;
    logic        cts_r, cts_nxt;
    logic        rxv_r, rxv_nxt;
    logic [7:0]  rxd_r, rxd_nxt;
    logic        rxs_r, rxs_nxt;

    function automatic logic route_second(input logic chan_bit,
                                          input logic first_en);
        route_second = (chan_bit == ifsp_pkg::CHAN_SECOND) || !first_en;
    endfunction

    // Count of the rise that carries the channel bit
    function automatic logic last_bit(input logic [3:0] cnt);
        last_bit = (cnt == ifsp_pkg::BIT_CNT_LAST);
    endfunction

    assign port_en = (opt_first_en || opt_second_en)
                     && (bit_mode != ifsp_pkg::MODE_HOLD_RST);
    assign pins_on_second = opt_first_en || opt_second_en;

    // Two-flop synchronisers; third clock flop for edge detect
    always_comb begin
        clk_s1_nxt = iso_serial_clock;
        clk_s2_nxt = clk_s1_r;
        clk_s3_nxt = clk_s2_r;
        din_s1_nxt = iso_serial_in;
        din_s2_nxt = din_s1_r;
    end

    // Reset to idle pin levels so no false edge follows reset
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clk_s1_r <= 1'b0;
            clk_s2_r <= 1'b0;
            clk_s3_r <= 1'b0;
            din_s1_r <= ifsp_pkg::IDLE_LEVEL;
            din_s2_r <= ifsp_pkg::IDLE_LEVEL;
        end else begin
            clk_s1_r <= clk_s1_nxt;
            clk_s2_r <= clk_s2_nxt;
            clk_s3_r <= clk_s3_nxt;
            din_s1_r <= din_s1_nxt;
            din_s2_r <= din_s2_nxt;
        end
    end

    // Shift register, count and serial out move only on far-end clock rises
    assign rise = clk_s2_r && !clk_s3_r;

    // Framer: shared shift register, half duplex by construction
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        shreg_nxt = shreg_r;
        sout_nxt  = sout_r;
        cts_nxt   = cts_r;
        tx_ready  = 1'b0;
        deliver   = 1'b0;
        case (state_r)
            ifsp_pkg::IFSP_IDLE: begin
                if (!rxv_r)
                    cts_nxt = 1'b1;
                if (rise) begin
                    // Channel bit stood one period; line back high
                    sout_nxt = ifsp_pkg::IDLE_LEVEL;
                    // Incoming start wins a tie with our own start while CTS is high
                    if (din_s2_r == ifsp_pkg::START_LEVEL && cts_r) begin
                        state_nxt = ifsp_pkg::IFSP_RX;
                        cts_nxt   = 1'b0;
                        cnt_nxt   = ifsp_pkg::BIT_CNT_ZERO;
                    end else if (tx_valid) begin
                        tx_ready  = 1'b1;
                        shreg_nxt = {tx_origin, tx_data};
                        sout_nxt  = ifsp_pkg::START_LEVEL;
                        cnt_nxt   = ifsp_pkg::BIT_CNT_ZERO;
                        state_nxt = ifsp_pkg::IFSP_TX;
                    end
                end
            end
            ifsp_pkg::IFSP_RX: begin
                cts_nxt = 1'b0;
                if (rise) begin
                    shreg_nxt = {din_s2_r, shreg_r[8:1]};
                    cnt_nxt   = cnt_r + 4'h1;
                    if (last_bit(cnt_r))
                        state_nxt = ifsp_pkg::IFSP_DELIVER;
                end
            end
            ifsp_pkg::IFSP_DELIVER: begin
                // Waits for the holding slot; CTS stays low meanwhile
                if (!rxv_r) begin
                    deliver   = 1'b1;
                    state_nxt = ifsp_pkg::IFSP_IDLE;
                end
            end
            ifsp_pkg::IFSP_TX: begin
                cts_nxt = 1'b0;
                // Far end stalls the clock to hold us here
                if (rise) begin
                    sout_nxt  = shreg_r[0];
                    shreg_nxt = {ifsp_pkg::IDLE_LEVEL, shreg_r[8:1]};
                    cnt_nxt   = cnt_r + 4'h1;
                    // Done on the channel bit: ten rises end a frame
                    if (last_bit(cnt_r))
                        state_nxt = ifsp_pkg::IFSP_IDLE;
                end
            end
            default: state_nxt = ifsp_pkg::IFSP_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn || !port_en) begin
            state_r <= ifsp_pkg::IFSP_IDLE;
            cnt_r   <= ifsp_pkg::BIT_CNT_ZERO;
            shreg_r <= '0;
            sout_r  <= ifsp_pkg::IDLE_LEVEL;
            cts_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            shreg_r <= shreg_nxt;
            sout_r  <= sout_nxt;
            cts_r   <= cts_nxt;
        end
    end

    // One-byte holding slot; drain and fill never meet
    always_comb begin
        rxv_nxt = rxv_r;
        rxd_nxt = rxd_r;
        rxs_nxt = rxs_r;
        if (rxv_r && rx_ready)
            rxv_nxt = 1'b0;
        if (deliver) begin
            rxv_nxt = 1'b1;
            rxd_nxt = shreg_r[ifsp_pkg::DATA_BITS-1:0];
            rxs_nxt = route_second(shreg_r[8], opt_first_en);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn || !port_en) begin
            rxv_r <= 1'b0;
            rxd_r <= '0;
            rxs_r <= ifsp_pkg::CHAN_FIRST;
        end else begin
            rxv_r <= rxv_nxt;
            rxd_r <= rxd_nxt;
            rxs_r <= rxs_nxt;
        end
    end

    assign iso_serial_out    = sout_r;
    assign iso_clear_to_send = cts_r;
    assign rx_valid          = rxv_r;
    assign rx_data           = rxd_r;
    assign rx_to_second      = rxs_r;
endmodule // ifsp_core

// ### ifsp_far.sv
// Far-end controller model that owns the serial clock
`timescale 1ns/100ps
module ifsp_far (
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic cts
);
    initial begin
        sclk = 1'b0;
        sdi  = 1'b1;
    end
    // Clock toggles only inside frames; sdo read on falling edge
    task automatic frame(input logic [9:0] tx, input int stall,
                         output logic [9:0] rx);
        if (!tx[0]) wait (cts);
        for (int i = 0; i < 10; i++) begin
            sdi = tx[i];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
            rx[i] = sdo;
            if (i == 0) #stall;
        end
        sdi = 1'b1;
    endtask
endmodule // ifsp_far

// ### ifsp_props.sv
// Concurrent checks on the serial port boundary
`timescale 1ns/100ps
module ifsp_props (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       opt_first_en,
    input wire logic       opt_second_en,
    input wire logic [7:0] bit_mode,
    input wire logic       iso_serial_clock,
    input wire logic       iso_serial_in,
    input wire logic       iso_serial_out,
    input wire logic       iso_clear_to_send,
    input wire logic       pins_on_second,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       rx_valid,
    input wire logic       rx_to_second,
    input wire logic       rx_ready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_still; !iso_serial_clock [*8]; endsequence
    sequence s_start;
        $rose(iso_serial_clock) && !iso_serial_in && iso_clear_to_send;
    endsequence
    AST_PINS: assert property (
        pins_on_second == (opt_first_en || opt_second_en))
        else $error("pin select wrong");
    AST_HOLD: assert property (
        bit_mode == ifsp_pkg::MODE_HOLD_RST
        |=> !iso_clear_to_send && iso_serial_out)
        else $error("hold not applied");
    AST_OFF: assert property (
        !(opt_first_en || opt_second_en)
        |=> !iso_clear_to_send && !rx_valid)
        else $error("port not disabled");
    AST_TXGO: assert property (
        tx_valid && tx_ready |=> !iso_serial_out)
        else $error("no start bit");
    AST_STILL: assert property (
        s_still |-> $stable(iso_serial_out))
        else $error("out moved without clock");
    AST_CTSDROP: assert property (
        s_start |-> ##[1:5] !iso_clear_to_send)
        else $error("cts not dropped");
    AST_KEEP: assert property (
        rx_valid && !rx_ready |=> !iso_clear_to_send)
        else $error("cts high with byte held");
    AST_ROUTE: assert property (
        $rose(rx_valid) && !opt_first_en |-> rx_to_second)
        else $error("route wrong");
endmodule // ifsp_props

// ### ifsp_core_tb.sv
// Self-checking bench for the isolated fast serial port
`timescale 1ns/100ps
module ifsp_core_tb;
    logic mclk = 0, rstn = 0, opt_first_en = 1, opt_second_en = 1;
    logic [7:0] bit_mode = 8'h00, tx_data = 8'h00, rx_data;
    logic tx_valid = 0, tx_origin = 0, rx_ready = 0, tx_ready, rx_valid;
    logic iso_serial_clock, iso_serial_in, iso_serial_out;
    logic iso_clear_to_send, pins_on_second, rx_to_second;
    logic [9:0] got;
    int fails = 0, comparisons = 0;
    // Rows: outgoing, channel, expected route, byte
    logic [10:0] rows [4] = '{11'h001, 11'h380, 11'h4a5, 11'h75a};
    ifsp_core u_dut (.mclk, .rstn, .opt_first_en, .opt_second_en,
        .bit_mode, .iso_serial_clock, .iso_serial_in, .iso_serial_out,
        .iso_clear_to_send, .pins_on_second, .tx_valid, .tx_data,
        .tx_origin, .tx_ready, .rx_valid, .rx_data, .rx_to_second,
        .rx_ready);
    ifsp_far u_far (.sclk(iso_serial_clock), .sdi(iso_serial_in),
        .sdo(iso_serial_out), .cts(iso_clear_to_send));
    always #5 mclk = ~mclk;
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (fails == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic take(input logic [8:0] exp);
        @(posedge mclk) #1;
        for (int i = 0; i < 20 && rx_valid !== 1'b1; i++)
            @(posedge mclk) #1;
        check({rx_to_second, rx_data}, exp);
        check(iso_clear_to_send, 0);
        @(posedge mclk) #1 rx_ready = 1;
        @(posedge mclk) #1 rx_ready = 0;
        repeat (3) @(posedge mclk);
        check(iso_clear_to_send, 1);
    endtask
    task automatic post(input logic [8:0] v);
        @(posedge mclk) #1 {tx_origin, tx_data} = v;
        tx_valid = 1;
    endtask
    // Holds the byte until the edge that takes it, then lowers valid
    task automatic drop;
        for (int i = 0; i < 2000 && tx_ready !== 1'b1; i++)
            @(posedge mclk) #1;
        check(tx_ready, 1);
        @(posedge mclk) #1 tx_valid = 0;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        #1 rstn = 1;
        repeat (4) @(posedge mclk);
        #1 check({iso_serial_out, iso_clear_to_send, pins_on_second}, 7);
        foreach (rows[i]) begin
            if (rows[i][10]) begin
                post(rows[i][8:0]);
                fork
                    drop();
                    u_far.frame(10'h3ff, 300, got);
                join
                check(got, {rows[i][8:0], 1'b0});
            end else begin
                u_far.frame({rows[i][9], rows[i][7:0], 1'b0}, 0, got);
                check(got, 10'h3ff);
                take(rows[i][8:0]);
            end
        end
        post(9'h13c);
        u_far.frame({9'h077, 1'b0}, 0, got);
        check(got, 10'h3ff);
        take(9'h077);
        fork
            drop();
            u_far.frame(10'h3ff, 0, got);
        join
        check(got, {9'h13c, 1'b0});
        @(posedge mclk) #1 opt_first_en = 0;
        u_far.frame({9'h066, 1'b0}, 0, got);
        check(got, 10'h3ff);
        take(9'h166);
        @(posedge mclk) #1 opt_second_en = 0;
        repeat (3) @(posedge mclk);
        #1 check({iso_clear_to_send, pins_on_second}, 0);
        {opt_first_en, opt_second_en} = 2'b11;
        bit_mode = 8'h10;
        repeat (3) @(posedge mclk);
        #1 check({iso_serial_out, iso_clear_to_send}, 2);
        bit_mode = 8'h00;
        repeat (3) @(posedge mclk);
        #1 check(iso_clear_to_send, 1);
        end_sim();
    end
    initial begin
        #200000;
        fails++;
        end_sim();
    end
endmodule // ifsp_core_tb
bind ifsp_core ifsp_props u_props (.mclk, .rstn, .opt_first_en,
    .opt_second_en, .bit_mode, .iso_serial_clock, .iso_serial_in,
    .iso_serial_out, .iso_clear_to_send, .pins_on_second, .tx_valid,
    .tx_ready, .rx_valid, .rx_to_second, .rx_ready);
